/* File: cio_regs.svh */
// Timing and width constants for the card strobe and byte enable controller.
`ifndef CIO_REGS_SVH
`define CIO_REGS_SVH
`define CIO_CLK_NS 4
`define CIO_SETUP_NS 70
`define CIO_STROBE_NS 165
`define CIO_HOLD_NS 20
`define CIO_SETUP_CYC ((`CIO_SETUP_NS + `CIO_CLK_NS - 1) / `CIO_CLK_NS)
`define CIO_STROBE_CYC ((`CIO_STROBE_NS + `CIO_CLK_NS - 1) / `CIO_CLK_NS)
`define CIO_HOLD_CYC ((`CIO_HOLD_NS + `CIO_CLK_NS - 1) / `CIO_CLK_NS)
`define CIO_CNT_W 6
`define CIO_ADDR_W 26
`define CIO_DATA_W 16
`define CIO_RSP_W 17
`define CIO_RSP_ACK_BIT 16
`endif

/* File: cio_pkg.sv */
// Types shared by the card strobe controller and its response buffer.
`include "cio_regs.svh"
package cio_pkg;
	typedef enum logic [1:0] {
		CIO_IO_RD = 2'h0,
		CIO_IO_WR = 2'h1,
		CIO_DMA_TO_HOST = 2'h2,
		CIO_DMA_TO_CARD = 2'h3
	} cio_kind_t;
	typedef enum logic [2:0] {
		CIO_ST_IDLE = 3'h0,
		CIO_ST_DMA_WAIT = 3'h1,
		CIO_ST_SETUP = 3'h2,
		CIO_ST_STROBE = 3'h3,
		CIO_ST_HOLD = 3'h4,
		CIO_ST_PUSH = 3'h5
	} cio_state_t;
	typedef logic [`CIO_RSP_W-1:0] cio_rsp_t;
endpackage : cio_pkg

/* File: cio_stream_if.sv */
// Valid and ready stream carrying one response word.
interface cio_stream_if;
	import cio_pkg::*;
	logic valid;
	logic ready;
	cio_rsp_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : cio_stream_if

/* File: cio_buf.sv */
// Two-entry response buffer with registered valid, data and ready.
module cio_buf (
	input wire logic clk_sys, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	cio_stream_if.snk in_s, // Filling side.
	cio_stream_if.src out_s // Draining side.
);
	import cio_pkg::*;
	cio_rsp_t head_r, head_nxt, tail_r, tail_nxt;
	logic head_v_r, head_v_nxt, tail_v_r, tail_v_nxt;
	logic push, pop;

	// Ready is the spare slot being empty, so it never depends on the drain in the same cycle.
	assign in_s.ready = ~tail_v_r;
	assign out_s.valid = head_v_r;
	assign out_s.data = head_r;
	assign push = in_s.valid & ~tail_v_r;
	assign pop = head_v_r & out_s.ready;

	// Head is what the receiver sees; tail catches a word that arrives while the head stalls.
	always_comb begin
		head_nxt = head_r;
		head_v_nxt = head_v_r;
		tail_nxt = tail_r;
		tail_v_nxt = tail_v_r;
		if (pop) begin
			if (tail_v_r) begin
				head_nxt = tail_r;
				tail_v_nxt = 1'b0;
			end else if (push) begin
				head_nxt = in_s.data;
			end else begin
				head_v_nxt = 1'b0;
			end
		end else if (push) begin
			if (!head_v_r) begin
				head_nxt = in_s.data;
				head_v_nxt = 1'b1;
			end else begin
				tail_nxt = in_s.data;
				tail_v_nxt = 1'b1;
			end
		end
	end

	// Buffer registers.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			head_r <= '0;
			tail_r <= '0;
			head_v_r <= 1'b0;
			tail_v_r <= 1'b0;
		end else begin
			head_r <= head_nxt;
			tail_r <= tail_nxt;
			head_v_r <= head_v_nxt;
			tail_v_r <= tail_v_nxt;
		end
	end
endmodule : cio_buf

/* File: cio_top.sv */
// Card socket controller for byte enables, I/O strobes, DMA acknowledge and input acknowledge.
// Functional notes
// - Even byte enable selects the even-addressed byte lane.
// - Odd byte enable selects the odd-addressed byte lane.
// - In DMA mode the input acknowledge line serves as the card's DMA request.
// - Host I/O reads assert the I/O read strobe for card data output.
// - DMA card-to-host transfers use the I/O read strobe per transfer.
// - Host I/O writes drive the I/O write strobe low to latch data.
// - DMA host-to-card transfers assert the I/O write strobe per transfer.
// - During DMA the attribute select acts as DMA acknowledge with the strobe.
// - Attribute select is asserted for I/O accesses, high otherwise.
// - Card wait extends the cycle; the strobe is not ended while wait holds.
`include "cio_regs.svh"
module cio_top (
	input wire logic clk_sys, // System clock, 250 MHz.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic req_valid, // Request offered.
	output logic req_ready, // Request can be taken.
	input wire cio_pkg::cio_kind_t req_kind, // Access kind.
	input wire logic req_word, // One for a 16-bit word access.
	input wire logic [`CIO_ADDR_W-1:0] req_addr, // Card address.
	input wire logic [`CIO_DATA_W-1:0] req_wdata, // Write data.
	input wire logic dma_mode, // Input acknowledge is the DMA request.
	output logic rsp_valid, // Read response available.
	input wire logic rsp_ready, // Receiver takes the response.
	output logic [`CIO_DATA_W-1:0] rsp_data, // Read data.
	output logic rsp_acked, // Card acknowledged the read.
	output logic even_byte_enable_n, // Even lane enable, active low.
	output logic odd_byte_enable_n, // Odd lane enable, active low.
	output logic io_read_strobe_n, // I/O read strobe, active low.
	output logic io_write_strobe_n, // I/O write strobe, active low.
	output logic dma_ack_n, // Attribute select and DMA acknowledge, active low.
	output logic [`CIO_ADDR_W-1:0] card_addr, // Card address pins.
	output logic [`CIO_DATA_W-1:0] card_data_o, // Data driven to the card.
	output logic card_data_oe_n, // Data drive enable, low while driving.
	input wire logic [`CIO_DATA_W-1:0] card_data_i, // Data from the card.
	input wire logic input_ack_n, // Input acknowledge from the card, active low.
	input wire logic wait_n // Cycle wait from the card, active low.
);
	import cio_pkg::*;

	// Enables for one access: word on both lanes, byte on the lane of address bit zero.
	function automatic logic [1:0] lane_enables_n(input logic word, input logic a0);
		lane_enables_n = word ? 2'h0 : (a0 ? 2'h1 : 2'h2);
	endfunction : lane_enables_n

	cio_stream_if rsp_in ();
	cio_stream_if rsp_out ();

	// Two-flop synchronisers for every pin input.
	logic ack_m_r, ack_s_r, wait_m_r, wait_s_r;
	logic [`CIO_DATA_W-1:0] din_m_r, din_s_r;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ack_m_r <= 1'b1;
			ack_s_r <= 1'b1;
			wait_m_r <= 1'b1;
			wait_s_r <= 1'b1;
			din_m_r <= '0;
			din_s_r <= '0;
		end else begin
			ack_m_r <= input_ack_n;
			ack_s_r <= ack_m_r;
			wait_m_r <= wait_n;
			wait_s_r <= wait_m_r;
			din_m_r <= card_data_i;
			din_s_r <= din_m_r;
		end
	end

	cio_state_t state_r, state_nxt;
	cio_kind_t kind_r, kind_nxt;
	logic [`CIO_CNT_W-1:0] cnt_r, cnt_nxt;
	logic [1:0] ben_r, ben_nxt;
	logic rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt, attr_r, attr_nxt, oe_r, oe_nxt, rdy_r, rdy_nxt;
	logic [`CIO_ADDR_W-1:0] addr_r, addr_nxt;
	logic [`CIO_DATA_W-1:0] wdata_r, wdata_nxt;
	cio_rsp_t cap_r, cap_nxt;
	logic is_read;

	assign is_read = (kind_r == CIO_IO_RD) || (kind_r == CIO_DMA_TO_HOST);

	// Access sequencer: setup with enables, strobe of least width stretched by wait, hold.
	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		cnt_nxt = cnt_r;
		ben_nxt = ben_r;
		rd_n_nxt = rd_n_r;
		wr_n_nxt = wr_n_r;
		attr_nxt = attr_r;
		oe_nxt = oe_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		cap_nxt = cap_r;
		unique case (state_r)
			CIO_ST_IDLE: begin
				if (req_valid && rdy_r) begin
					kind_nxt = req_kind;
					addr_nxt = req_addr;
					wdata_nxt = req_wdata;
					cnt_nxt = '0;
					ben_nxt = lane_enables_n(req_word, req_addr[0]);
					attr_nxt = 1'b0;
					oe_nxt = ~((req_kind == CIO_IO_WR) || (req_kind == CIO_DMA_TO_CARD));
					if ((req_kind == CIO_DMA_TO_HOST) || (req_kind == CIO_DMA_TO_CARD)) begin
						attr_nxt = 1'b1;
						ben_nxt = 2'h3;
						state_nxt = CIO_ST_DMA_WAIT;
					end else begin
						state_nxt = CIO_ST_SETUP;
					end
				end
			end
			CIO_ST_DMA_WAIT: begin
				// The card's request arrives on the input acknowledge line.
				if (dma_mode && !ack_s_r) begin
					ben_nxt = lane_enables_n(1'b1, 1'b0);
					attr_nxt = 1'b0;
					state_nxt = CIO_ST_SETUP;
				end
			end
			CIO_ST_SETUP: begin
				if (cnt_r == `CIO_CNT_W'(`CIO_SETUP_CYC - 1)) begin
					cnt_nxt = '0;
					rd_n_nxt = ~is_read;
					wr_n_nxt = is_read;
					state_nxt = CIO_ST_STROBE;
				end else begin
					cnt_nxt = cnt_r + `CIO_CNT_W'(1);
				end
			end
			CIO_ST_STROBE: begin
				if (cnt_r != `CIO_CNT_W'(`CIO_STROBE_CYC - 1)) begin
					cnt_nxt = cnt_r + `CIO_CNT_W'(1);
				end else if (wait_s_r) begin
					cap_nxt = {~ack_s_r, din_s_r};
					rd_n_nxt = 1'b1;
					wr_n_nxt = 1'b1;
					cnt_nxt = '0;
					state_nxt = CIO_ST_HOLD;
				end
			end
			CIO_ST_HOLD: begin
				if (cnt_r == `CIO_CNT_W'(`CIO_HOLD_CYC - 1)) begin
					cnt_nxt = '0;
					ben_nxt = 2'h3;
					attr_nxt = 1'b1;
					oe_nxt = 1'b1;
					state_nxt = is_read ? CIO_ST_PUSH : CIO_ST_IDLE;
				end else begin
					cnt_nxt = cnt_r + `CIO_CNT_W'(1);
				end
			end
			CIO_ST_PUSH: begin
				// A full buffer holds the word here, so a stalled receiver loses nothing.
				if (rsp_in.ready) begin
					state_nxt = CIO_ST_IDLE;
				end
			end
			default: begin
				state_nxt = CIO_ST_IDLE;
			end
		endcase
		rdy_nxt = (state_nxt == CIO_ST_IDLE);
	end

	// Sequencer registers; all card pins come straight from these.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_r <= CIO_ST_IDLE;
			kind_r <= CIO_IO_RD;
			cnt_r <= '0;
			ben_r <= 2'h3;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			attr_r <= 1'b1;
			oe_r <= 1'b1;
			rdy_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= '0;
			cap_r <= '0;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			cnt_r <= cnt_nxt;
			ben_r <= ben_nxt;
			rd_n_r <= rd_n_nxt;
			wr_n_r <= wr_n_nxt;
			attr_r <= attr_nxt;
			oe_r <= oe_nxt;
			rdy_r <= rdy_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			cap_r <= cap_nxt;
		end
	end

	// Strobes are kept active low in their flops, so no gate sits between flop and pin.
	assign even_byte_enable_n = ben_r[0];
	assign odd_byte_enable_n = ben_r[1];
	assign io_read_strobe_n = rd_n_r;
	assign io_write_strobe_n = wr_n_r;
	assign dma_ack_n = attr_r;
	assign card_addr = addr_r;
	assign card_data_o = wdata_r;
	assign card_data_oe_n = oe_r;
	assign req_ready = rdy_r;

	// Read responses pass through the two-entry buffer.
	assign rsp_in.valid = (state_r == CIO_ST_PUSH);
	assign rsp_in.data = cap_r;
	assign rsp_out.ready = rsp_ready;
	assign rsp_valid = rsp_out.valid;
	assign rsp_data = rsp_out.data[`CIO_DATA_W-1:0];
	assign rsp_acked = rsp_out.data[`CIO_RSP_ACK_BIT];

	cio_buf u_buf (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_s(rsp_in),
		.out_s(rsp_out)
	);
endmodule : cio_top

/* File: cio_chk_sva.sv */
// Concurrent checks on the card strobe controller's ports.
`include "cio_regs.svh"
module cio_chk
	import cio_pkg::*;
(
	input wire logic clk_sys, // Clock.
	input wire logic reset, // Reset.
	input wire logic req_valid, // Offer.
	input wire logic req_ready, // Accept.
	input wire cio_pkg::cio_kind_t req_kind, // Kind.
	input wire logic req_word, // Word.
	input wire logic rsp_valid, // Response.
	input wire logic rsp_ready, // Taken.
	input wire logic [`CIO_DATA_W-1:0] rsp_data, // Data.
	input wire logic wait_n, // Wait.
	input wire logic even_byte_enable_n, // Even lane.
	input wire logic odd_byte_enable_n, // Odd lane.
	input wire logic io_read_strobe_n, // Read strobe.
	input wire logic io_write_strobe_n, // Write strobe.
	input wire logic dma_ack_n, // Attribute select.
	input wire logic [`CIO_ADDR_W-1:0] card_addr, // Address.
	input wire logic card_data_oe_n // Drive enable.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic take;
	logic io_take;
	// A take of a host I/O request, the cause of the lane checks.
	assign take = req_valid && req_ready;
	assign io_take = take && (req_kind inside {CIO_IO_RD, CIO_IO_WR});
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	strobe_excl_a: assert property (!(!io_read_strobe_n && !io_write_strobe_n))
		else $error("both strobes low");
	read_ctx_a: assert property (!io_read_strobe_n |-> !dma_ack_n && !req_ready)
		else $error("read strobe without select");
	write_ctx_a: assert property (!io_write_strobe_n |-> !dma_ack_n && !card_data_oe_n)
		else $error("write strobe without select or drive");
	even_lane_a: assert property (!even_byte_enable_n && odd_byte_enable_n |-> !card_addr[0])
		else $error("even lane on odd address");
	odd_lane_a: assert property (even_byte_enable_n && !odd_byte_enable_n |-> card_addr[0])
		else $error("odd lane on even address");
	word_both_a: assert property (io_take && req_word |-> ##[1:2] (!even_byte_enable_n
		&& !odd_byte_enable_n)) else $error("word access lacks a lane");
	byte_one_a: assert property (io_take && !req_word |-> ##[1:2] (even_byte_enable_n
		!= odd_byte_enable_n)) else $error("byte access lanes wrong");
	wait_hold_a: assert property ((!io_read_strobe_n && !wait_n) [*4] |=> !io_read_strobe_n)
		else $error("read strobe ended during wait");
	idle_attr_a: assert property (even_byte_enable_n && odd_byte_enable_n |-> dma_ack_n)
		else $error("select outside an access");
	rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
		else $error("response dropped while stalled");
	// Main scenarios reached by the bench.
	dma_c: cover property (take && req_kind == CIO_DMA_TO_HOST);
	wait_c: cover property (!wait_n && !io_read_strobe_n);
	stall_c: cover property (rsp_valid && !rsp_ready);
endmodule : cio_chk
bind cio_top cio_chk u_chk (.clk_sys, .reset, .req_valid, .req_ready, .req_kind, .req_word,
	.rsp_valid, .rsp_ready, .rsp_data, .wait_n, .even_byte_enable_n, .odd_byte_enable_n,
	.io_read_strobe_n, .io_write_strobe_n, .dma_ack_n, .card_addr, .card_data_oe_n);

/* File: cio_card.sv */
// Behavioural card model answering the strobes.
module cio_card (
	input wire logic clk_sys, // Clock.
	input wire logic io_read_strobe_n, // Read strobe.
	input wire logic io_write_strobe_n, // Write strobe.
	input wire logic [25:0] card_addr, // Address.
	input wire logic [15:0] card_data_o, // Write data.
	input wire logic dma_req, // Bench wants a DMA.
	input wire logic [7:0] wait_len, // Wait per strobe.
	output logic [15:0] card_data_i, // Read data.
	output logic input_ack_n, // Acknowledge or request.
	output logic wait_n, // Wait, active low.
	output logic [15:0] wr_seen // Last latched word.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rd_val;
	logic [7:0] wcnt = 8'h00;
	logic st_d = 1'b1;
	logic wr_d = 1'b1;
	// Released data is inverted so a late sample by the host cannot pass.
	always_comb begin
		rd_val = dma_req ? 16'hD5A3 : {card_addr[7:0], ~card_addr[7:0]};
		card_data_i = io_read_strobe_n ? ~rd_val : rd_val;
		input_ack_n = io_read_strobe_n ? !dma_req : !(dma_req || card_addr < 26'h100);
	end
	// Wait starts at each strobe fall; write data is latched as the strobe rises.
	always @(posedge clk_sys) begin
		st_d <= io_read_strobe_n && io_write_strobe_n;
		wr_d <= io_write_strobe_n;
		if (st_d && !(io_read_strobe_n && io_write_strobe_n))
			wcnt <= wait_len;
		else if (wcnt != 8'h00)
			wcnt <= wcnt - 8'h01;
		if (!wr_d && io_write_strobe_n)
			wr_seen <= card_data_o;
	end
	assign wait_n = (wcnt == 8'h00);
endmodule : cio_card

/* File: cio_top_tb.sv */
// Self-checking bench for the card strobe controller.
module cio_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cio_pkg::*;
	logic clk_sys = 0, reset = 1, req_valid = 0, req_word = 0, dma_mode = 0, rsp_ready = 1;
	logic dma_req = 0, req_ready, rsp_valid, rsp_acked, even_byte_enable_n, odd_byte_enable_n;
	logic io_read_strobe_n, io_write_strobe_n, dma_ack_n, card_data_oe_n, input_ack_n, wait_n;
	cio_kind_t req_kind = CIO_IO_RD;
	logic [25:0] req_addr = 26'h0, card_addr;
	logic [15:0] req_wdata = 16'h0, rsp_data, card_data_o, card_data_i, wr_seen;
	logic [7:0] wait_len = 8'h00, run = 8'h00, last_len = 8'h00;
	logic [1:0] lanes = 2'h3;
	int fails = 0, n_checks = 0;
	cio_top DUT (.clk_sys, .reset, .req_valid, .req_ready, .req_kind, .req_word, .req_addr,
		.req_wdata, .dma_mode, .rsp_valid, .rsp_ready, .rsp_data, .rsp_acked, .even_byte_enable_n,
		.odd_byte_enable_n, .io_read_strobe_n, .io_write_strobe_n, .dma_ack_n, .card_addr,
		.card_data_o, .card_data_oe_n, .card_data_i, .input_ack_n, .wait_n);
	cio_card u_card (.clk_sys, .io_read_strobe_n, .io_write_strobe_n, .card_addr, .card_data_o,
		.dma_req, .wait_len, .card_data_i, .input_ack_n, .wait_n, .wr_seen);
	initial forever #2 clk_sys = ~clk_sys;
	// Lanes seen under a strobe and the length of the last read strobe.
	always @(posedge clk_sys) begin
		if (!io_read_strobe_n || !io_write_strobe_n) lanes <= {odd_byte_enable_n, even_byte_enable_n};
		run <= io_read_strobe_n ? 8'h00 : run + 8'h01;
		if (!io_read_strobe_n) last_len <= run + 8'h01;
	end
	task automatic chk(input logic [16:0] s, input logic [16:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	// Offer one request and hold it until the edge that takes it.
	task automatic go(input cio_kind_t k, input logic w, input logic [25:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_kind = k;
		req_word = w;
		req_addr = a;
		req_wdata = d;
		while (req_ready !== 1'b1 && n < 3000) begin @(negedge clk_sys); n++; end
		// A request never taken counts as a mismatch.
		if (n >= 3000) fails++;
		@(negedge clk_sys);
		req_valid = 1'b0;
	endtask : go
	task automatic idle_wait;
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 3000) begin @(negedge clk_sys); n++; end
		if (n >= 3000) fails++;
	endtask : idle_wait
	task automatic get(input logic [16:0] e);
		int n;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 3000) begin @(negedge clk_sys); n++; end
		// A response that never comes counts as a mismatch, whatever stale data shows.
		if (n >= 3000) fails++;
		chk({rsp_acked, rsp_data}, e);
		@(negedge clk_sys);
	endtask : get
	function automatic logic [16:0] ans(input logic [25:0] a);
		return {a < 26'h100, a[7:0], ~a[7:0]};
	endfunction : ans
	task automatic t_reads;
		logic [25:0] a [4] = '{26'h10, 26'h11, 26'h12, 26'h200};
		logic [1:0] el [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
		for (int i = 0; i < 4; i++) begin
			go(CIO_IO_RD, a[i] > 26'h12 || a[i] == 26'h10, a[i], 16'h0000);
			get(ans(a[i]));
			chk(lanes, el[i]);
		end
	endtask : t_reads
	task automatic t_writes;
		go(CIO_IO_WR, 1'b1, 26'h40, 16'hA55A);
		idle_wait();
		chk(wr_seen, 16'hA55A);
		chk(lanes, 2'h0);
		go(CIO_IO_WR, 1'b0, 26'h43, 16'h3CC3);
		idle_wait();
		chk(wr_seen, 16'h3CC3);
		chk(lanes, 2'h1);
	endtask : t_writes
	task automatic t_wait;
		wait_len = 8'h3C;
		go(CIO_IO_RD, 1'b1, 26'h20, 16'h0000);
		get(ans(26'h20));
		chk(last_len > 8'h3B, 1'b1);
		wait_len = 8'h00;
	endtask : t_wait
	task automatic t_dma;
		dma_mode = 1'b1;
		go(CIO_DMA_TO_HOST, 1'b1, 26'h0, 16'h0000);
		repeat (20) @(negedge clk_sys);
		chk({io_read_strobe_n, dma_ack_n}, 2'h3);
		dma_req = 1'b1;
		get({1'b1, 16'hD5A3});
		dma_req = 1'b0;
		go(CIO_DMA_TO_CARD, 1'b1, 26'h0, 16'h7E81);
		dma_req = 1'b1;
		idle_wait();
		dma_req = 1'b0;
		chk(wr_seen, 16'h7E81);
		dma_mode = 1'b0;
	endtask : t_dma
	// Three reads against a stalled receiver; the buffer keeps two and the sequencer holds the third, all in order.
	task automatic t_stall;
		rsp_ready = 1'b0;
		for (int i = 0; i < 3; i++) go(CIO_IO_RD, 1'b1, 26'(26'h30 + i), 16'h0000);
		repeat (80) @(negedge clk_sys);
		chk(rsp_valid, 1'b1);
		rsp_ready = 1'b1;
		for (int i = 0; i < 3; i++) get(ans(26'(26'h30 + i)));
	endtask : t_stall
	initial begin
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		t_reads();
		t_writes();
		t_wait();
		t_dma();
		t_stall();
		wrap_up();
	end
	// Cuts a hang short well past the expected few thousand nanoseconds.
	initial begin
		#60000;
		fails++;
		wrap_up();
	end
endmodule : cio_top_tb
